/* File: common/lic_regs.vh */
`ifndef LIC_REGS_VH
`define LIC_REGS_VH

// system clock
`define LIC_CLK_MHZ      40
// internal operation time after each executed instruction
`define LIC_BUSY_NS      1000
`define LIC_BUSY_CYC     ((`LIC_BUSY_NS * `LIC_CLK_MHZ + 999) / 1000)

// slave address on the serial port (arbitrary)
`define LIC_I2C_ADDR     7'h3b

// function set fields
`define LIC_FS_DL        4
`define LIC_FS_M         2
`define LIC_FS_H         0
// set voltage fields
`define LIC_SV_SEL       6
// control byte fields on the serial port
`define LIC_CB_CO        7
`define LIC_CB_RS        6

// reset values
`define LIC_RST_DL       1'b1
`define LIC_RST_VOLT     6'h00
`define LIC_RST_TC       2'b00

// icon geometry
`define LIC_ICON_COUNT   120
`define LIC_ICONS_ROW    5
`define LIC_ROWS_CHAR    8

`endif

/* File: rtl/lic_i2c_slave.v */
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.vh"

module lic_i2c_slave (
    input  wire       sys_clk,
    input  wire       nrst,
    input  wire       clk_en,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe_ff,
    output reg        rx_valid_ff,
    output reg  [7:0] rx_byte_ff,
    output reg        rx_rs_ff,
    input  wire [7:0] tx_byte
);
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_RX    = 3'd1;
    localparam [2:0] S_RXACK = 3'd2;
    localparam [2:0] S_TX    = 3'd3;
    localparam [2:0] S_TXACK = 3'd4;
    localparam [6:0] SLV_ADR = `LIC_I2C_ADDR;

    reg [1:0] scl_m_ff, sda_m_ff;
    reg       scl_s_ff, sda_s_ff, scl_d_ff, sda_d_ff;
    reg [2:0] state_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] sh_ff;
    reg       adr_ph_ff, rd_ff, ctl_ph_ff, co_ff, nack_ff;
    wire      scl_rise = scl_s_ff & ~scl_d_ff;
    wire      scl_fall = ~scl_s_ff & scl_d_ff;
    wire      start_c  = scl_s_ff & scl_d_ff & ~sda_s_ff & sda_d_ff;
    wire      stop_c   = scl_s_ff & scl_d_ff & sda_s_ff & ~sda_d_ff;

    // only low is ever driven; the clock line is never touched
    assign sda_out = 1'b0;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scl_m_ff    <= 2'b11;
            sda_m_ff    <= 2'b11;
            scl_s_ff    <= 1'b1;
            sda_s_ff    <= 1'b1;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
            state_ff    <= S_IDLE;
            bit_cnt_ff  <= 4'h0;
            sh_ff       <= 8'h00;
            adr_ph_ff   <= 1'b0;
            rd_ff       <= 1'b0;
            ctl_ph_ff   <= 1'b1;
            co_ff       <= 1'b0;
            nack_ff     <= 1'b0;
            sda_oe_ff   <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_byte_ff  <= 8'h00;
            rx_rs_ff    <= 1'b0;
        end else if (clk_en) begin
            scl_m_ff    <= {scl_m_ff[0], scl_in};
            sda_m_ff    <= {sda_m_ff[0], sda_in};
            scl_s_ff    <= scl_m_ff[1];
            sda_s_ff    <= sda_m_ff[1];
            scl_d_ff    <= scl_s_ff;
            sda_d_ff    <= sda_s_ff;
            rx_valid_ff <= 1'b0;
            if (start_c) begin
                state_ff   <= S_RX;
                bit_cnt_ff <= 4'h0;
                adr_ph_ff  <= 1'b1;
                ctl_ph_ff  <= 1'b1;
                sda_oe_ff  <= 1'b0;
            end else if (stop_c) begin
                state_ff  <= S_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    S_RX: begin
                        if (scl_rise) begin
                            sh_ff      <= {sh_ff[6:0], sda_s_ff};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                            if (adr_ph_ff) begin
                                adr_ph_ff <= 1'b0;
                                rd_ff     <= sh_ff[0];
                                if (sh_ff[7:1] == SLV_ADR) begin
                                    state_ff  <= S_RXACK;
                                    sda_oe_ff <= 1'b1;
                                end else begin
                                    state_ff <= S_IDLE;
                                end
                            end else begin
                                state_ff  <= S_RXACK;
                                sda_oe_ff <= 1'b1;
                                if (ctl_ph_ff) begin
                                    co_ff     <= sh_ff[`LIC_CB_CO];
                                    rx_rs_ff  <= sh_ff[`LIC_CB_RS];
                                    ctl_ph_ff <= 1'b0;
                                end else begin
                                    rx_byte_ff  <= sh_ff;
                                    rx_valid_ff <= 1'b1;
                                    ctl_ph_ff   <= co_ff;
                                end
                            end
                        end
                    end
                    S_RXACK: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            if (rd_ff) begin
                                state_ff  <= S_TX;
                                sh_ff     <= {tx_byte[6:0], 1'b0};
                                sda_oe_ff <= ~tx_byte[7];
                            end else begin
                                state_ff  <= S_RX;
                                sda_oe_ff <= 1'b0;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_ff == 4'h7) begin
                                state_ff  <= S_TXACK;
                                sda_oe_ff <= 1'b0;
                            end else begin
                                sda_oe_ff  <= ~sh_ff[7];
                                sh_ff      <= {sh_ff[6:0], 1'b0};
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    S_TXACK: begin
                        if (scl_rise) begin
                            nack_ff <= sda_s_ff;
                        end else if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            if (nack_ff) begin
                                state_ff  <= S_IDLE;
                                sda_oe_ff <= 1'b0;
                            end else begin
                                state_ff  <= S_TX;
                                sh_ff     <= {tx_byte[6:0], 1'b0};
                                sda_oe_ff <= ~tx_byte[7];
                            end
                        end
                    end
                    default: begin
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // lic_i2c_slave

`default_nettype wire

/* File: rtl/lic_host_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.vh"

module lic_host_port (
    input  wire       sys_clk,
    input  wire       nrst,
    input  wire       clk_en,
    input  wire       par_strobe,
    input  wire       register_select,
    input  wire       par_read_sel,
    input  wire [7:0] parallel_data_lines_in,
    output reg  [7:0] parallel_data_lines_out,
    output wire [7:0] parallel_data_lines_oe,
    output wire [3:0] low_lines_pullup,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire       power_down,
    input  wire [6:0] icon_sel,
    input  wire       blink_odd_phase,
    output reg        icon_on,
    output reg        icon_blink_enable,
    output reg        icon_mode_select,
    output reg        split_mirror,
    output reg        col_mirror,
    output reg        row_mirror,
    output reg        temp_coeff_sel_hi,
    output reg        temp_coeff_sel_lo,
    output reg  [5:0] lcd_drive_voltage,
    output reg        vgen_enable,
    output reg        bus_width_select,
    output reg        ext_instr_set,
    output reg        two_line_mode,
    output reg        display_on,
    output wire       internal_op_pending
);
    localparam integer BUSY_CYC = `LIC_BUSY_CYC;
    localparam [7:0]   BUSY_LD  = BUSY_CYC[7:0];

    function [5:0] icon_addr;
        input [6:0] sel;
        input       odd;
        reg   [6:0] chr;
        reg   [6:0] row;
        begin
            chr       = sel / 7'd40;
            row       = (sel % 7'd40) / 7'd5;
            icon_addr = {odd, chr[1:0], row[2:0]};
        end
    endfunction

    function [2:0] icon_bit;
        input [6:0] sel;
        reg   [6:0] pos;
        begin
            pos      = 7'd4 - (sel % 7'd5);
            icon_bit = pos[2:0];
        end
    endfunction

    reg  [4:0] char_generator_ram [0:63];
    reg  [1:0] e_m_ff, rs_m_ff, rw_m_ff, pd_m_ff;
    reg  [7:0] db_m_ff, db_s_ff;
    reg        e_s_ff, rs_s_ff, rw_s_ff, pd_s_ff, e_d_ff;
    reg        nib_ff;
    reg  [3:0] hi_nib_ff;
    reg        pend_ff, pend_rs_ff, pend_ser_ff;
    reg  [7:0] pend_byte_ff;
    reg  [7:0] busy_cnt_ff;
    reg  [6:0] addr_ctr_ff;
    reg  [5:0] volt_char_ff, volt_icon_ff;
    reg        cg_sel_ff;
    reg        rd_en_ff;
    wire       ser_valid, ser_rs;
    wire [7:0] ser_byte;
    wire       e_fall = ~e_s_ff & e_d_ff;
    wire       busy = busy_cnt_ff != 8'h00;
    wire       exec = pend_ff & ~busy;
    wire [4:0] dr_val = char_generator_ram[addr_ctr_ff[5:0]];
    wire [7:0] stat_val = {internal_op_pending, addr_ctr_ff};
    reg  [7:0] rd_val;
    reg        par_done;
    reg  [7:0] par_byte;
    reg  [5:0] ic_addr;
    reg  [5:0] sel_volt;

    assign internal_op_pending = pend_ff | busy;
    assign low_lines_pullup = {4{~bus_width_select}};
    assign parallel_data_lines_oe = {{4{rd_en_ff}}, {4{rd_en_ff & bus_width_select}}};

    lic_i2c_slave u_ser (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .clk_en      (clk_en),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sda_out     (sda_out),
        .sda_oe_ff   (sda_oe),
        .rx_valid_ff (ser_valid),
        .rx_byte_ff  (ser_byte),
        .rx_rs_ff    (ser_rs),
        .tx_byte     (rd_val)
    );

    always @* begin
        // serial read source follows the last control byte
        rd_val = ser_rs ? {3'b000, dr_val} : stat_val;
        par_done = 1'b0;
        par_byte = db_s_ff;
        if (e_fall && !rw_s_ff) begin
            if (bus_width_select) begin
                par_done = 1'b1;
            end else if (nib_ff) begin
                par_done = 1'b1;
                par_byte = {hi_nib_ff, db_s_ff[7:4]};
            end
        end
    end

    always @* begin
        ic_addr  = icon_addr(icon_sel, icon_blink_enable & blink_odd_phase);
        sel_volt = icon_mode_select ? volt_icon_ff : volt_char_ff;
    end

    // pin synchronisers and parallel strobe tracking
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            e_m_ff    <= 2'b00;
            rs_m_ff   <= 2'b00;
            rw_m_ff   <= 2'b00;
            pd_m_ff   <= 2'b00;
            db_m_ff   <= 8'hff;
            e_s_ff    <= 1'b0;
            rs_s_ff   <= 1'b0;
            rw_s_ff   <= 1'b0;
            pd_s_ff   <= 1'b0;
            db_s_ff   <= 8'hff;
            e_d_ff    <= 1'b0;
            nib_ff    <= 1'b0;
            hi_nib_ff <= 4'h0;
            rd_en_ff  <= 1'b0;
            parallel_data_lines_out <= 8'h00;
        end else if (clk_en) begin
            e_m_ff  <= {e_m_ff[0], par_strobe};
            rs_m_ff <= {rs_m_ff[0], register_select};
            rw_m_ff <= {rw_m_ff[0], par_read_sel};
            pd_m_ff <= {pd_m_ff[0], power_down};
            db_m_ff <= parallel_data_lines_in;
            e_s_ff  <= e_m_ff[1];
            rs_s_ff <= rs_m_ff[1];
            rw_s_ff <= rw_m_ff[1];
            pd_s_ff <= pd_m_ff[1];
            db_s_ff <= db_m_ff;
            e_d_ff  <= e_s_ff;
            rd_en_ff <= e_s_ff & rw_s_ff;
            if (bus_width_select) begin
                parallel_data_lines_out <= rs_s_ff ? {3'b000, dr_val} : stat_val;
            end else if (!nib_ff) begin
                parallel_data_lines_out <= rs_s_ff ? {3'b000, dr_val[4], 4'hf} : {stat_val[7:4], 4'hf};
            end else begin
                parallel_data_lines_out <= rs_s_ff ? {dr_val[3:0], 4'hf} : {stat_val[3:0], 4'hf};
            end
            if (bus_width_select) begin
                nib_ff <= 1'b0;
            end else if (e_fall) begin
                nib_ff <= ~nib_ff;
                if (!nib_ff)
                    hi_nib_ff <= db_s_ff[7:4];
            end
        end
    end

    // pending instruction and busy time
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pend_ff      <= 1'b0;
            pend_rs_ff   <= 1'b0;
            pend_ser_ff  <= 1'b0;
            pend_byte_ff <= 8'h00;
            busy_cnt_ff  <= 8'h00;
        end else if (clk_en) begin
            if (exec) begin
                pend_ff     <= 1'b0;
                busy_cnt_ff <= BUSY_LD;
            end else if (busy) begin
                busy_cnt_ff <= busy_cnt_ff - 8'h01;
            end
            if (par_done) begin
                pend_ff      <= 1'b1;
                pend_rs_ff   <= rs_s_ff;
                pend_ser_ff  <= 1'b0;
                pend_byte_ff <= par_byte;
            end else if (ser_valid) begin
                pend_ff      <= 1'b1;
                pend_rs_ff   <= ser_rs;
                pend_ser_ff  <= 1'b1;
                pend_byte_ff <= ser_byte;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (clk_en && exec && pend_rs_ff && cg_sel_ff)
            char_generator_ram[addr_ctr_ff[5:0]] <= pend_byte_ff[4:0];
    end

    // instruction execution
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            icon_blink_enable <= 1'b0;
            icon_mode_select  <= 1'b0;
            split_mirror      <= 1'b0;
            col_mirror        <= 1'b0;
            row_mirror        <= 1'b0;
            temp_coeff_sel_hi <= 1'b0;
            temp_coeff_sel_lo <= 1'b0;
            volt_char_ff      <= `LIC_RST_VOLT;
            volt_icon_ff      <= `LIC_RST_VOLT;
            bus_width_select  <= `LIC_RST_DL;
            ext_instr_set     <= 1'b0;
            two_line_mode     <= 1'b0;
            display_on        <= 1'b0;
            addr_ctr_ff       <= 7'h00;
            cg_sel_ff         <= 1'b0;
        end else if (clk_en && exec) begin
            if (pend_rs_ff) begin
                addr_ctr_ff <= addr_ctr_ff + 7'h01;
            end else if (pend_byte_ff[7:5] == 3'b001) begin
                bus_width_select <= pend_ser_ff | pend_byte_ff[`LIC_FS_DL];
                two_line_mode    <= pend_byte_ff[`LIC_FS_M];
                ext_instr_set    <= pend_byte_ff[`LIC_FS_H];
            end else if (!ext_instr_set) begin
                casez (pend_byte_ff)
                    8'b1???_????: begin
                        addr_ctr_ff <= pend_byte_ff[6:0];
                        cg_sel_ff   <= 1'b0;
                    end
                    8'b01??_????: begin
                        addr_ctr_ff <= {addr_ctr_ff[6], pend_byte_ff[5:0]};
                        cg_sel_ff   <= 1'b1;
                    end
                    8'b0000_1???: begin
                        display_on <= pend_byte_ff[2];
                    end
                    default: begin
                        cg_sel_ff <= cg_sel_ff;
                    end
                endcase
            end else begin
                casez (pend_byte_ff)
                    8'b1???_????: begin
                        if (pend_byte_ff[`LIC_SV_SEL])
                            volt_icon_ff <= pend_byte_ff[5:0];
                        else
                            volt_char_ff <= pend_byte_ff[5:0];
                    end
                    8'b0001_00??: begin
                        temp_coeff_sel_hi <= pend_byte_ff[1];
                        temp_coeff_sel_lo <= pend_byte_ff[0];
                    end
                    8'b0000_1???: begin
                        icon_mode_select  <= pend_byte_ff[2];
                        icon_blink_enable <= pend_byte_ff[1];
                    end
                    8'b0000_01??: begin
                        col_mirror <= pend_byte_ff[1];
                        row_mirror <= pend_byte_ff[0];
                    end
                    8'b0000_001?: begin
                        split_mirror <= pend_byte_ff[0];
                    end
                    default: begin
                        cg_sel_ff <= cg_sel_ff;
                    end
                endcase
            end
        end
    end

    // icon state and voltage generator control
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            icon_on           <= 1'b0;
            lcd_drive_voltage <= `LIC_RST_VOLT;
            vgen_enable       <= 1'b0;
        end else if (clk_en) begin
            icon_on           <= char_generator_ram[ic_addr][icon_bit(icon_sel)];
            lcd_drive_voltage <= sel_volt;
            vgen_enable       <= (sel_volt != 6'h00) & display_on & ~pd_s_ff;
        end
    end
endmodule // lic_host_port

`default_nettype wire

/* File: tb/lic_host_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lic_host_port_assertions (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       par_strobe,
    input wire logic       power_down,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] parallel_data_lines_oe,
    input wire logic [3:0] low_lines_pullup,
    input wire logic       bus_width_select,
    input wire logic       split_mirror,
    input wire logic       col_mirror,
    input wire logic       row_mirror,
    input wire logic       temp_coeff_sel_hi,
    input wire logic       temp_coeff_sel_lo,
    input wire logic [5:0] lcd_drive_voltage,
    input wire logic       vgen_enable,
    input wire logic       display_on,
    input wire logic       internal_op_pending
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    reset_vals_a: assert property ($rose(nrst) |-> bus_width_select && !split_mirror && !col_mirror
        && !row_mirror && !temp_coeff_sel_hi && !temp_coeff_sel_lo) else $error("config bits off reset value");
    vgen_off_a: assert property ((!display_on || lcd_drive_voltage == 6'h00) [*3] |-> !vgen_enable)
        else $error("generator on with zero voltage or display off");
    pd_off_a: assert property (power_down [*5] |-> !vgen_enable) else $error("generator on in power-down");
    pullup_a: assert property (low_lines_pullup == (bus_width_select ? 4'h0 : 4'hf))
        else $error("low line pull-ups wrong for width");
    nib_oe_a: assert property (!bus_width_select |-> parallel_data_lines_oe[3:0] == 4'h0)
        else $error("low lines driven in nibble mode");
    idle_oe_a: assert property (!par_strobe [*5] |-> parallel_data_lines_oe == 8'h00)
        else $error("data lines driven without strobe");
    sda_low_a: assert property (sda_out == 1'b0) else $error("serial data not pulled low");
    sda_rel_a: assert property ((scl_in && sda_in) [*8] |-> !sda_oe) else $error("serial data held on idle bus");
    busy_hold_a: assert property ($rose(internal_op_pending) |-> internal_op_pending [*8])
        else $error("busy dropped early");
    busy_end_a: assert property ($rose(internal_op_pending) |-> ##[1:60] !internal_op_pending)
        else $error("busy too long");
endmodule // lic_host_port_assertions
bind lic_host_port lic_host_port_assertions lic_host_port_assertions_i (.sys_clk(sys_clk), .nrst(nrst),
    .par_strobe(par_strobe), .power_down(power_down), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .parallel_data_lines_oe(parallel_data_lines_oe), .low_lines_pullup(low_lines_pullup),
    .bus_width_select(bus_width_select), .split_mirror(split_mirror), .col_mirror(col_mirror),
    .row_mirror(row_mirror), .temp_coeff_sel_hi(temp_coeff_sel_hi), .temp_coeff_sel_lo(temp_coeff_sel_lo),
    .lcd_drive_voltage(lcd_drive_voltage), .vgen_enable(vgen_enable), .display_on(display_on),
    .internal_op_pending(internal_op_pending));
`default_nettype wire

/* File: tb/lic_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lic_mcu_model (
    input  wire logic       sys_clk,
    input  wire logic       pending,
    input  wire logic [7:0] pin,
    output var  logic       stb,
    output var  logic       rs,
    output var  logic       rd,
    output var  logic [7:0] md,
    output var  logic       scl,
    output var  logic       sda,
    input  wire logic       sda_line
);
    initial {stb, rs, rd, md, scl, sda} = 13'h0003;
    // one strobe cycle, each level held 6 cycles
    task automatic cyc(input logic r, input logic w_rd, input logic [7:0] d, output logic [7:0] q);
        for (int i = 0; i < 200 && pending; i++) @(posedge sys_clk);
        rs <= r;
        rd <= w_rd;
        md <= w_rd ? ~md : d;
        stb <= 1'b1;
        repeat (6) @(posedge sys_clk);
        q = pin;
        stb <= 1'b0;
        repeat (6) @(posedge sys_clk);
        for (int i = 0; i < 200 && pending; i++) @(posedge sys_clk);
    endtask
    // whole byte, or high then low nibble on lines 7:4
    task automatic put(input logic r, input logic [7:0] d, input logic nib);
        logic [7:0] q;
        if (nib) begin
            cyc(r, 1'b0, {d[7:4], 4'hf}, q);
            cyc(r, 1'b0, {d[3:0], 4'hf}, q);
        end else
            cyc(r, 1'b0, d, q);
    endtask
    // serial bit of 200 ns: data set mid low phase, line read mid high phase
    task automatic sbit(input logic b, output logic s);
        scl <= 1'b0;
        repeat (2) @(posedge sys_clk);
        sda <= b;
        repeat (2) @(posedge sys_clk);
        scl <= 1'b1;
        repeat (2) @(posedge sys_clk);
        s = sda_line;
        repeat (2) @(posedge sys_clk);
    endtask
    // optional start, byte msb first, ninth bit released; ack when pulled low
    task automatic sbyte(input logic st, input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic s;
        if (st) begin
            sda <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        for (int i = 7; i >= 0; i--) begin
            sbit(d[i], s);
            q[i] = s;
        end
        sbit(1'b1, s);
        ack = ~s;
    endtask
    // stop: data rises while clock high
    task automatic sstop;
        logic s;
        sbit(1'b0, s);
        sda <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule // lic_mcu_model
`default_nettype wire

/* File: tb/tb_lic_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.vh"
module tb_lic_host_port;
    logic       sys_clk, nrst, power_down, blink_odd_phase, nib;
    logic [6:0] icon_sel;
    logic [7:0] q;
    wire        stb, rs, rd, sda_out, sda_oe, icon_on, ibe, ims, spl, colm, rowm, tch, tcl, vgen, bw, ext, tlm, don, pend;
    wire  [7:0] md, pin, dout, doe;
    wire  [3:0] pu;
    wire        scl, msda, sda_line;
    wire  [5:0] volt;
    int         n_mismatch, n_compared, cyc_cnt;
    assign pin = (dout & doe) | (~doe & (md | {4'h0, pu}));
    assign sda_line = msda & ~sda_oe;
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    lic_host_port lic_host_port_i (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .par_strobe(stb),
        .register_select(rs), .par_read_sel(rd), .parallel_data_lines_in(pin), .parallel_data_lines_out(dout),
        .parallel_data_lines_oe(doe), .low_lines_pullup(pu), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .power_down(power_down), .icon_sel(icon_sel), .blink_odd_phase(blink_odd_phase),
        .icon_on(icon_on), .icon_blink_enable(ibe), .icon_mode_select(ims), .split_mirror(spl), .col_mirror(colm),
        .row_mirror(rowm), .temp_coeff_sel_hi(tch), .temp_coeff_sel_lo(tcl), .lcd_drive_voltage(volt),
        .vgen_enable(vgen), .bus_width_select(bw), .ext_instr_set(ext), .two_line_mode(tlm), .display_on(don),
        .internal_op_pending(pend));
    lic_mcu_model lic_mcu_model_i (.sys_clk(sys_clk), .pending(pend), .pin(pin), .stb(stb), .rs(rs), .rd(rd), .md(md),
        .scl(scl), .sda(msda), .sda_line(sda_line));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic ins(input logic [7:0] b);
        lic_mcu_model_i.put(1'b0, b, nib);
    endtask
    task automatic ic(input logic [6:0] n, input logic odd, input logic e);
        icon_sel <= n;
        blink_odd_phase <= odd;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, icon_on}, {7'h0, e});
    endtask
    task automatic t_config;
        ins(8'h35);
        chk({6'h0, tlm, ext}, 8'h03);
        for (int i = 0; i < 4; i++) begin
            ins(8'h10 | i[7:0]);
            chk({6'h0, tch, tcl}, i[7:0]);
            ins(8'h04 | i[7:0]);
            chk({6'h0, colm, rowm}, i[7:0]);
        end
        ins(8'h03);
        chk({7'h0, spl}, 8'h01);
        ins(8'h02);
        chk({7'h0, spl}, 8'h00);
    endtask
    task automatic t_voltage;
        ins(8'h95);
        ins(8'hFF);
        chk({2'h0, volt}, 8'h15);
        ins(8'h30);
        ins(8'h0C);
        chk({6'h0, don, vgen}, 8'h03);
        power_down <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({7'h0, vgen}, 8'h00);
        power_down <= 1'b0;
        ins(8'h31);
        ins(8'h0C);
        chk({ims, 1'b0, volt}, 8'hBF);
        ins(8'h80);
        ins(8'hC0);
        chk({vgen, 1'b0, volt}, 8'h00);
        ins(8'h08);
    endtask
    task automatic t_icons;
        ins(8'h30);
        ins(8'h40);
        lic_mcu_model_i.put(1'b1, 8'h15, nib);
        ins(8'h60);
        lic_mcu_model_i.put(1'b1, 8'h0A, nib);
        ic(7'd0, 1'b1, 1'b1);
        ic(7'd1, 1'b1, 1'b0);
        ins(8'h31);
        ins(8'h0A);
        chk({7'h0, ibe}, 8'h01);
        ic(7'd0, 1'b1, 1'b0);
        ic(7'd1, 1'b1, 1'b1);
        ic(7'd0, 1'b0, 1'b1);
        ic(7'd2, 1'b0, 1'b1);
    endtask
    task automatic t_nibble;
        ins(8'h20);
        nib = 1'b1;
        chk({3'h0, bw, pu}, 8'h0F);
        ins(8'hA5);
        lic_mcu_model_i.cyc(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'h2F);
        lic_mcu_model_i.cyc(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'h5F);
        ins(8'h21);
        chk({7'h0, ext}, 8'h01);
    endtask
    task automatic t_serial;
        logic [7:0] r;
        logic       a;
        lic_mcu_model_i.sbyte(1'b1, {`LIC_I2C_ADDR, 1'b0}, r, a);
        chk({7'h0, a}, 8'h01);
        lic_mcu_model_i.sbyte(1'b0, 8'h00, r, a);
        chk({7'h0, a}, 8'h01);
        lic_mcu_model_i.sbyte(1'b0, 8'h20, r, a);
        chk({7'h0, a}, 8'h01);
        lic_mcu_model_i.sstop;
        repeat (60) @(posedge sys_clk);
        chk({6'h0, bw, ext}, 8'h02);
        lic_mcu_model_i.sbyte(1'b1, {`LIC_I2C_ADDR, 1'b1}, r, a);
        chk({7'h0, a}, 8'h01);
        lic_mcu_model_i.sbyte(1'b0, 8'hFF, r, a);
        chk(r, 8'h25);
        chk({7'h0, a}, 8'h00);
        lic_mcu_model_i.sstop;
    endtask
    always @(posedge sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        {nrst, power_down, blink_odd_phase, nib, icon_sel} = '0;
        {n_mismatch, n_compared, cyc_cnt} = '0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({2'h0, spl, colm, rowm, tch, tcl, bw}, 8'h01);
        t_config;
        t_voltage;
        t_icons;
        t_nibble;
        t_serial;
        tally_and_finish;
    end
endmodule // tb_lic_host_port
`default_nettype wire
